/* File: cbl_cfg.svh */
/*
 Constants for the code byte and pointer step load executor: opcodes, field
 positions, reset values and cycle counts. Assumes one instruction-cycle clock.
*/
// Functional notes
// - The code byte load has an index-pair form and an accumulator form, each one byte and three cycles long.
// - In the accumulator form the fetched byte replaces the accumulator after the address has been formed.
// - The fetch address is the five top program counter bits joined to the selected 8-bit pair as low byte.
// - The index-pair form leaves the index pair unchanged; only the accumulator takes the byte.
// - The upper fetched nibble goes to the high accumulator nibble, the lower one to the low nibble.
// - The page bits come from the advanced program counter, so a load at a page's last byte reads the next page.
// - The step-down load copies the nibble at the pointer pair into the accumulator, then decrements the low pointer.
// - When the decremented low pointer wraps to 0FH the next instruction is skipped.
// - The step-up load copies the nibble at the pointer pair into the accumulator, then increments the low pointer.
// - When the incremented low pointer wraps to 0H the next instruction is skipped.
// - Both step loads leave data memory and the carry flag unchanged, skip or not.
// - The step-down load takes two cycles plus the skip cycles only when a borrow skips.
// - The extended accumulator is an 8-bit pair whose high nibble acts as a pair's high register.
`ifndef CBL_CFG_SVH
`define CBL_CFG_SVH
`define CBL_OP_CODE_INDEX  8'hCC
`define CBL_OP_CODE_ACC    8'hC8
`define CBL_OP_STEP_DOWN   8'h8B
`define CBL_OP_STEP_UP     8'h8A
`define CBL_CODE_CYCLES    3
`define CBL_STEP_CYCLES    2
`define CBL_PAGE_HI        12
`define CBL_PAGE_LO        8
`define CBL_WRAP_DOWN      4'hF
`define CBL_WRAP_UP        4'h0
`define CBL_RESET_NIBBLE   4'h0
`endif

/* File: cbl_pkg.sv */
/*
 Types for the code byte and pointer step load executor.
 Assumes the constants header is included by the user.
*/
package cbl_pkg;
   typedef struct packed {
      logic [3:0] hi;
      logic [3:0] lo;
   } cbl_pair_s;
   typedef enum logic [1:0] {
      CBL_IDLE,
      CBL_FETCH,
      CBL_WRITE
   } cbl_state_e;
   typedef enum logic [1:0] {
      CBL_K_INDEX,
      CBL_K_ACC,
      CBL_K_DOWN,
      CBL_K_UP
   } cbl_kind_e;
endpackage

/* File: cbl_exec.sv */
/*
 Executor for the code byte load and the two pointer step loads.
 Assumes the fetch unit offers one opcode per instruction cycle with the
 already advanced program counter, and that program memory and data RAM
 answer combinationally to the address driven in the same cycle.
 Also assumes the core honours skip_next by dropping the next instruction
 (fetched for its own length) without side effects.
*/
`timescale 1ns/1ns
`include "cbl_cfg.svh"
module cbl_exec
   import cbl_pkg::*;
#(
   parameter int PC_W = 13
) (
   input  wire logic            ref_clk,
   input  wire logic            rst_n,
   input  wire logic            op_valid,
   input  wire logic [7:0]      opcode,
   input  wire logic [PC_W-1:0] pc_next,
   input  wire cbl_pair_s       index_pair,
   input  wire cbl_pair_s       pointer_pair_in,
   input  wire logic [7:0]      code_data,
   input  wire logic [3:0]      ram_data,
   output logic                 busy,
   output logic [PC_W-1:0]      code_addr,
   output logic                 code_rd,
   output logic [7:0]           ram_addr,
   output logic                 ram_rd,
   output cbl_pair_s            extended_accumulator,
   output cbl_pair_s            pointer_pair,
   output logic                 pointer_we,
   output logic                 acc_we,
   output logic                 skip_next,
   output logic                 done
);
   cbl_state_e state;
   cbl_kind_e  kind;
   logic       hit;
   cbl_kind_e  next_kind;
   logic [3:0] next_lo;

   always_comb begin
      hit       = op_valid && !busy;
      next_kind = CBL_K_INDEX;
      unique case (opcode)
         `CBL_OP_CODE_ACC:  next_kind = CBL_K_ACC;
         `CBL_OP_STEP_DOWN: next_kind = CBL_K_DOWN;
         `CBL_OP_STEP_UP:   next_kind = CBL_K_UP;
         default:           next_kind = CBL_K_INDEX;
      endcase
      if (opcode != `CBL_OP_CODE_INDEX && opcode != `CBL_OP_CODE_ACC &&
          opcode != `CBL_OP_STEP_DOWN && opcode != `CBL_OP_STEP_UP) begin
         hit = 1'b0;
      end
      next_lo = (kind == CBL_K_DOWN) ? pointer_pair.lo - 4'h1 : pointer_pair.lo + 4'h1;
   end

   // Sequencer: code loads idle-fetch-write (3), step loads idle-write (2)
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= CBL_IDLE;
         kind  <= CBL_K_INDEX;
         busy  <= 1'b0;
      end else begin
         unique case (state)
            CBL_IDLE: if (hit) begin
               kind  <= next_kind;
               busy  <= 1'b1;
               state <= (next_kind == CBL_K_DOWN || next_kind == CBL_K_UP) ? CBL_WRITE : CBL_FETCH;
            end
            CBL_FETCH: state <= CBL_WRITE;
            CBL_WRITE: begin
               state <= CBL_IDLE;
               busy  <= 1'b0;
            end
         endcase
      end
   end

   // Address forming; page from the advanced PC, low byte from the pair
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         code_addr <= '0;
         code_rd   <= 1'b0;
         ram_addr  <= 8'h00;
         ram_rd    <= 1'b0;
      end else begin
         code_rd <= 1'b0;
         ram_rd  <= 1'b0;
         if (state == CBL_IDLE && hit) begin
            if (next_kind == CBL_K_ACC) begin
               code_addr <= {pc_next[PC_W-1:`CBL_PAGE_LO], extended_accumulator};
               code_rd   <= 1'b1;
            end else if (next_kind == CBL_K_INDEX) begin
               code_addr <= {pc_next[PC_W-1:`CBL_PAGE_LO], index_pair};
               code_rd   <= 1'b1;
            end else begin
               ram_addr <= pointer_pair_in;
               ram_rd   <= 1'b1;
            end
         end
      end
   end

   // Accumulator; read only, so RAM and carry are never touched
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         extended_accumulator <= '{hi: `CBL_RESET_NIBBLE, lo: `CBL_RESET_NIBBLE};
         acc_we               <= 1'b0;
      end else begin
         acc_we <= 1'b0;
         if (code_rd) begin
            extended_accumulator <= '{hi: code_data[7:4], lo: code_data[3:0]};
            acc_we               <= 1'b1;
         end else if (ram_rd) begin
            extended_accumulator.lo <= ram_data;
            acc_we                  <= 1'b1;
         end
      end
   end

   // Pointer stepping and skip; high nibble never carries
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pointer_pair <= '{hi: `CBL_RESET_NIBBLE, lo: `CBL_RESET_NIBBLE};
         pointer_we   <= 1'b0;
         skip_next    <= 1'b0;
         done         <= 1'b0;
      end else begin
         pointer_we <= 1'b0;
         // Skip is only flagged; the core drops the next instruction itself
         skip_next  <= 1'b0;
         done       <= 1'b0;
         if (!busy) begin
            pointer_pair <= pointer_pair_in;
         end
         if (state == CBL_WRITE) begin
            done <= 1'b1;
            if (kind == CBL_K_DOWN || kind == CBL_K_UP) begin
               pointer_pair.lo <= next_lo;
               pointer_we      <= 1'b1;
               skip_next       <= (kind == CBL_K_DOWN) ? (next_lo == `CBL_WRAP_DOWN)
                                                       : (next_lo == `CBL_WRAP_UP);
            end
         end
      end
   end

   property p_code_three;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == CBL_IDLE && hit && (next_kind == CBL_K_INDEX || next_kind == CBL_K_ACC)) |=>
         ##1 state == CBL_WRITE ##1 done;
   endproperty
   a_code_three: assert property (p_code_three) else $error("code load not three cycles");

   property p_index_form;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == CBL_IDLE && hit && next_kind == CBL_K_INDEX) |=>
         code_addr == {$past(pc_next[PC_W-1:8]), $past(index_pair)};
   endproperty
   a_index_form: assert property (p_index_form) else $error("index form address wrong");

   property p_step_addr;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == CBL_IDLE && hit && (next_kind == CBL_K_DOWN || next_kind == CBL_K_UP)) |=>
         ram_addr == $past(pointer_pair_in);
   endproperty
   a_step_addr: assert property (p_step_addr) else $error("step load address wrong");

   property p_step_lo;
      @(posedge ref_clk) disable iff (!rst_n)
      pointer_we |-> pointer_pair.lo == ((kind == CBL_K_DOWN) ? $past(pointer_pair.lo) - 4'h1 : $past(pointer_pair.lo) + 4'h1);
   endproperty
   a_step_lo: assert property (p_step_lo) else $error("low pointer not stepped by one");

   // An opcode offered while busy must never start a second access
   property p_no_retake;
      @(posedge ref_clk) disable iff (!rst_n) busy |=> !code_rd && !ram_rd;
   endproperty
   a_no_retake: assert property (p_no_retake) else $error("opcode taken while busy");

   property p_acc_load;
      @(posedge ref_clk) disable iff (!rst_n) code_rd |=> extended_accumulator == $past(code_data);
   endproperty
   a_acc_load: assert property (p_acc_load) else $error("fetched byte not in accumulator");

   property p_addr_page;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == CBL_IDLE && hit && next_kind == CBL_K_ACC) |=>
         code_addr == {$past(pc_next[PC_W-1:8]), $past(extended_accumulator)};
   endproperty
   a_addr_page: assert property (p_addr_page) else $error("code address wrong");

   property p_down_skip;
      @(posedge ref_clk) disable iff (!rst_n)
      (pointer_we && kind == CBL_K_DOWN) |-> skip_next == (pointer_pair.lo == 4'hF);
   endproperty
   a_down_skip: assert property (p_down_skip) else $error("down skip wrong");

   property p_up_skip;
      @(posedge ref_clk) disable iff (!rst_n)
      (pointer_we && kind == CBL_K_UP) |-> skip_next == (pointer_pair.lo == 4'h0);
   endproperty
   a_up_skip: assert property (p_up_skip) else $error("up skip wrong");

   property p_hi_kept;
      @(posedge ref_clk) disable iff (!rst_n) pointer_we |-> pointer_pair.hi == $past(pointer_pair.hi);
   endproperty
   a_hi_kept: assert property (p_hi_kept) else $error("high pointer changed");

   property p_step_two;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == CBL_IDLE && hit && (next_kind == CBL_K_DOWN || next_kind == CBL_K_UP)) |=> ram_rd ##1 done;
   endproperty
   a_step_two: assert property (p_step_two) else $error("step load not two cycles");

   property p_step_acc;
      @(posedge ref_clk) disable iff (!rst_n) ram_rd |=> extended_accumulator.lo == $past(ram_data) && acc_we;
   endproperty
   a_step_acc: assert property (p_step_acc) else $error("ram nibble not loaded");

   // Main scenarios
   c_down_wrap: cover property (@(posedge ref_clk) pointer_we && kind == CBL_K_DOWN && skip_next);
   c_up_wrap: cover property (@(posedge ref_clk) pointer_we && kind == CBL_K_UP && skip_next);
   c_acc_load: cover property (@(posedge ref_clk) code_rd && kind == CBL_K_ACC);
   c_index_load: cover property (@(posedge ref_clk) code_rd && kind == CBL_K_INDEX);
   c_step_no_skip: cover property (@(posedge ref_clk) pointer_we && !skip_next);
endmodule

/* File: cbl_mem_model.sv */
/*
 Partner model: program memory and data RAM, read only, combinational.
 Assumes the executor samples data in the cycle of its read strobe.
*/
`timescale 1ns/1ns
module cbl_mem_model
#(
   parameter int PC_W = 13
) (
   input  wire logic [PC_W-1:0] code_addr,
   input  wire logic            code_rd,
   input  wire logic [7:0]      ram_addr,
   input  wire logic            ram_rd,
   output logic [7:0]           code_data,
   output logic [3:0]           ram_data
);
   logic [7:0] code_word;
   logic [3:0] ram_word;
   // No write path, so stored data never changes
   assign code_word = code_addr[7:0] ^ {code_addr[PC_W-1:8], 3'h5};
   assign ram_word  = ram_addr[3:0] ^ ram_addr[7:4] ^ 4'h6;
   // Idle lines show the inverse so a read outside its strobe is caught
   assign code_data = code_rd ? code_word : ~code_word;
   assign ram_data  = ram_rd ? ram_word : ~ram_word;
endmodule

/* File: tb_cbl_exec.sv */
/*
 Testbench for the load executor: table of loads, then refusals and a mid-load reset.
 Assumes the memory model answers in the same cycle.
*/
`timescale 1ns/1ns
`include "cbl_cfg.svh"
module tb_cbl_exec
   import cbl_pkg::*;
;
   typedef struct packed {
      logic [7:0]  op;
      logic [12:0] pc;
      cbl_pair_s   idx;
      cbl_pair_s   ptr;
   } cbl_row_s;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        op_valid = 1'b0;
   logic [7:0]  opcode = 8'h00;
   logic [12:0] pc_next = 13'h0000;
   cbl_pair_s   index_pair = 8'h00;
   cbl_pair_s   pointer_pair_in = 8'h00;
   logic [7:0]  code_data, ram_addr;
   logic [3:0]  ram_data;
   logic [12:0] code_addr;
   logic        busy, code_rd, ram_rd, pointer_we, acc_we, skip_next, done;
   cbl_pair_s   extended_accumulator, pointer_pair;
   cbl_pair_s   acc = 8'h00;
   int          num_errors = 0;
   int          comparisons = 0;
   cbl_row_s    rows [8] = '{'{8'hCC, 13'h0123, 8'h5A, 8'h00}, '{8'hC8, 13'h1F00, 8'h00, 8'h00},
      '{8'hCC, 13'h0200, 8'h00, 8'h00}, '{8'h8B, 13'h0000, 8'h00, 8'h25},
      '{8'h8B, 13'h0000, 8'h00, 8'h20}, '{8'h8A, 13'h0000, 8'h00, 8'h2E},
      '{8'h8A, 13'h0000, 8'h00, 8'h2F}, '{8'hC8, 13'h0A00, 8'h00, 8'h00}};
   cbl_exec #(.PC_W(13)) i_cbl_exec (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid),
      .opcode(opcode), .pc_next(pc_next), .index_pair(index_pair), .pointer_pair_in(pointer_pair_in),
      .code_data(code_data), .ram_data(ram_data), .busy(busy), .code_addr(code_addr), .code_rd(code_rd),
      .ram_addr(ram_addr), .ram_rd(ram_rd), .extended_accumulator(extended_accumulator),
      .pointer_pair(pointer_pair), .pointer_we(pointer_we), .acc_we(acc_we), .skip_next(skip_next),
      .done(done));
   cbl_mem_model #(.PC_W(13)) i_cbl_mem_model (.code_addr(code_addr), .code_rd(code_rd),
      .ram_addr(ram_addr), .ram_rd(ram_rd), .code_data(code_data), .ram_data(ram_data));
   always #2 ref_clk = ~ref_clk;
   task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic run(input cbl_row_s r);
      logic [12:0] a;
      cbl_pair_s   p;
      logic        step;
      logic        up;
      int          n;
      int          w;
      up = r.op == `CBL_OP_STEP_UP;
      step = up || r.op == `CBL_OP_STEP_DOWN;
      a = {r.pc[12:8], (r.op == `CBL_OP_CODE_INDEX) ? r.idx : acc};
      p = r.ptr;
      p.lo = up ? p.lo + 4'h1 : p.lo - 4'h1;
      @(posedge ref_clk);
      op_valid <= 1'b1;
      opcode <= r.op;
      pc_next <= r.pc;
      index_pair <= r.idx;
      pointer_pair_in <= r.ptr;
      @(posedge ref_clk);
      op_valid <= 1'b0;
      n = 1;
      w = 0;
      #1;
      while (done !== 1'b1 && n < 8) begin
         if (code_rd === 1'b1) chk("code_addr", code_addr, a);
         if (ram_rd === 1'b1) chk("ram_addr", ram_addr, r.ptr);
         if (acc_we === 1'b1) w++;
         @(posedge ref_clk);
         #1;
         n++;
      end
      // Step loads fill only the low nibble; code loads the whole pair
      if (step)
         acc.lo = r.ptr.lo ^ r.ptr.hi ^ 4'h6;
      else
         acc = a[7:0] ^ {a[12:8], 3'h5};
      if (acc_we === 1'b1) w++;
      chk("acc_we", w, 1);
      chk("pointer_we", pointer_we, step);
      chk("cycles", n, step ? `CBL_STEP_CYCLES : `CBL_CODE_CYCLES);
      chk("accumulator", extended_accumulator, acc);
      chk("skip", skip_next, step && p.lo == (up ? `CBL_WRAP_UP : `CBL_WRAP_DOWN));
      if (step) chk("pointer", pointer_pair, p);
      @(posedge ref_clk);
      #1;
      chk("busy", busy, 1'b0);
   endtask
   initial begin
      #16000;
      num_errors++;
      complete_run;
   end
   initial begin
      int n;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk("reset", {busy, done, skip_next, extended_accumulator}, 13'h0000);
      foreach (rows[i]) run(rows[i]);
      // Unknown opcode, then a step load offered while busy: both dropped
      @(posedge ref_clk);
      op_valid <= 1'b1;
      opcode <= 8'hA0;
      @(posedge ref_clk);
      opcode <= `CBL_OP_CODE_INDEX;
      #1;
      chk("unknown", {busy, code_rd, ram_rd}, 13'h0000);
      @(posedge ref_clk);
      opcode <= `CBL_OP_STEP_UP;
      #1;
      chk("taken", busy, 1'b1);
      @(posedge ref_clk);
      op_valid <= 1'b0;
      #1;
      n = ram_rd;
      repeat (6) begin
         @(posedge ref_clk);
         #1;
         n += ram_rd;
      end
      chk("ignored", n, 0);
      // Reset in mid-load, held two edges, then a step load from a clean state
      @(posedge ref_clk);
      op_valid <= 1'b1;
      opcode <= `CBL_OP_CODE_ACC;
      @(posedge ref_clk);
      op_valid <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk("mid_reset", {busy, done, code_rd, skip_next, extended_accumulator}, 13'h0000);
      acc = 8'h00;
      run(rows[3]);
      complete_run;
   end
endmodule
